// ==== design/gpvdl_params.svh ====
// Constants of the pin value and descriptor length register bank.
// Assumes it is included by bare name; guarded against double inclusion.
`ifndef GPVDL_PARAMS_SVH
`define GPVDL_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets, byte addresses on APB
// ----------------------------------------------------------------------
`define GPVDL_ADDR_W         12
`define GPVDL_OFS_PIN_VALUE  12'h0ac
`define GPVDL_OFS_CAP_LEN    12'h100
`define GPVDL_OFS_SS_LEN     12'h104

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GPVDL_PIN_W          31
`define GPVDL_LEN_W          8
`define GPVDL_CAP_LEN_MSB    7
`define GPVDL_CAP_LEN_LSB    0
`define GPVDL_SS_POLL_MSB    23
`define GPVDL_SS_POLL_LSB    16
`define GPVDL_SS_DEV_MSB     15
`define GPVDL_SS_DEV_LSB     8
`define GPVDL_SS_CFG_MSB     7
`define GPVDL_SS_CFG_LSB     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GPVDL_PIN_VALUE_RST  31'h0000_0000
`define GPVDL_CAP_LEN_RST    8'h00
`define GPVDL_SS_POLL_RST    8'h06
`define GPVDL_SS_DEV_RST     8'h00
`define GPVDL_SS_CFG_RST     8'h00
`define GPVDL_DESC_ABSENT    8'h00

`endif

// ==== design/gpvdl_pkg.sv ====
// Types shared by the pin value and descriptor length register bank.
// Assumes gpvdl_params.svh is on the include path.
`include "gpvdl_params.svh"

package gpvdl_pkg;

    // ------------------------------------------------------------------
    // APB carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                      psel;
        logic                      penable;
        logic                      pwrite;
        logic [`GPVDL_ADDR_W-1:0]  paddr;
        logic [31:0]               pwdata;
        logic [3:0]                pstrb;
    } gpvdl_apb_req_t;

    typedef struct packed {
        logic [31:0]               prdata;
        logic                      pready;
        logic                      pslverr;
    } gpvdl_apb_rsp_t;

    // ------------------------------------------------------------------
    // Descriptor kinds and attribute fields
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        GPVDL_DESC_CAP    = 2'b00,
        GPVDL_DESC_SS_DEV = 2'b01,
        GPVDL_DESC_SS_CFG = 2'b10
    } gpvdl_desc_kind_t;

    typedef struct packed {
        logic [`GPVDL_LEN_W-1:0]   poll;
        logic [`GPVDL_LEN_W-1:0]   dev_len;
        logic [`GPVDL_LEN_W-1:0]   cfg_len;
    } gpvdl_superspeed_length_reg_t;

    typedef struct packed {
        logic [`GPVDL_PIN_W-1:0]   pin_value;
        logic [`GPVDL_PIN_W-1:0]   pin_image;
        logic [`GPVDL_PIN_W-1:0]   oe_n;
        logic                      image_valid;
        logic                      pins_enabled;
        logic [`GPVDL_LEN_W-1:0]   cap_len;
        gpvdl_superspeed_length_reg_t            ss;
        gpvdl_apb_rsp_t            rsp;
    } gpvdl_state_t;

endpackage

// ==== design/gpvdl_pin_sync.sv ====
// Three-stage synchroniser for asynchronous pin levels.
// Assumes pins may change at any time relative to clk_i.
`timescale 1ns/1ps

module gpvdl_pin_sync #(
    parameter int W = 31
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    // Levels
    input  wire logic [W-1:0]  async_i,
    output logic      [W-1:0]  level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
    } gpvdl_sync_state_t;

    gpvdl_sync_state_t st_reg;
    gpvdl_sync_state_t st_next;
    logic [W-1:0]      agree;

    // A bit is taken over only once the second and third stages agree.
    assign agree = ~(st_reg.s2 ^ st_reg.s3);

    always_comb begin
        st_next       = st_reg;
        st_next.s1    = async_i;
        st_next.s2    = st_reg.s1;
        st_next.s3    = st_reg.s2;
        st_next.level = (st_reg.level & ~agree) | (st_reg.s3 & agree);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.level;

    a_level_agreed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ((level_o ^ $past(level_o)) & ($past(st_reg.s2) ^ $past(st_reg.s3))) == '0)
        else $error("pin level changed before stages agreed");
endmodule

// ==== design/gpvdl_desc_len.sv ====
// Descriptor length lookup for emulated descriptor handling.
// Assumes requests come from logic on the same clock.
`timescale 1ns/1ps
`include "gpvdl_params.svh"

module gpvdl_desc_len
    import gpvdl_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Request
    input  wire logic                     req_i,
    input  wire gpvdl_desc_kind_t         kind_i,
    input  wire logic                     emul_i,
    // Attribute values
    input  wire logic [`GPVDL_LEN_W-1:0]  cap_len_i,
    input  wire gpvdl_superspeed_length_reg_t           ss_i,
    // Answer
    output logic                          valid_o,
    output logic      [`GPVDL_LEN_W-1:0]  len_o,
    output logic                          present_o
);
    typedef struct packed {
        logic                     valid;
        logic [`GPVDL_LEN_W-1:0]  len;
        logic                     present;
    } gpvdl_desc_state_t;

    gpvdl_desc_state_t st_reg;
    gpvdl_desc_state_t st_next;

    always_comb begin
        st_next       = st_reg;
        st_next.valid = req_i;
        if (req_i) begin
            st_next.len = `GPVDL_DESC_ABSENT;
            if (emul_i) begin
                unique case (kind_i)
                    GPVDL_DESC_CAP:    st_next.len = cap_len_i;
                    GPVDL_DESC_SS_DEV: st_next.len = ss_i.dev_len;
                    GPVDL_DESC_SS_CFG: st_next.len = ss_i.cfg_len;
                    default:           st_next.len = `GPVDL_DESC_ABSENT;
                endcase
            end
            st_next.present = (st_next.len != `GPVDL_DESC_ABSENT);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign valid_o   = st_reg.valid;
    assign len_o     = st_reg.len;
    assign present_o = st_reg.present;

    a_zero_absent: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        valid_o |-> (present_o == (len_o != 8'h00)))
        else $error("descriptor presence does not follow its length");

    a_emul_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (req_i && !emul_i) |=> (valid_o && !present_o && len_o == 8'h00))
        else $error("descriptor length used outside emulation");
endmodule

// ==== design/gpvdl_top.sv ====
// Pin value register and descriptor length attribute registers on APB.
// Assumes pin direction, reset protection, bus resets and the configuration
// image come from neighbouring logic on clk_i; pin levels are asynchronous.
//
// Functional notes
// - Output pins drive last written bit values.
// - Reads return sampled pin levels, any direction.
// - Configuration image loads pin value bits.
// - No configuration memory: pins undriven after reset.
// - Bus resets disable or restore pins.
// - Reset protection keeps contents across bus resets.
// - Capability length in bits 7:0, resets 00h.
// - Lengths used only in emulation without memory.
// - Capability block holds store and capability descriptors.
// - Polling interval bits 23:16, read-write, resets 06h.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "gpvdl_params.svh"

module gpvdl_top
    import gpvdl_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // APB slave
    input  wire gpvdl_apb_req_t           apb_i,
    output gpvdl_apb_rsp_t                apb_o,
    // Pins
    input  wire logic [`GPVDL_PIN_W-1:0]  pin_level_i,
    input  wire logic [`GPVDL_PIN_W-1:0]  pin_dir_i,
    output logic      [`GPVDL_PIN_W-1:0]  pin_out_o,
    output logic      [`GPVDL_PIN_W-1:0]  pin_oe_n_o,
    // Configuration memory and bus resets
    input  wire logic                     cfg_present_i,
    input  wire logic                     cfg_load_i,
    input  wire logic [`GPVDL_PIN_W-1:0]  cfg_pin_image_i,
    input  wire logic                     usb_reset_i,
    input  wire logic                     lite_soft_reset_i,
    input  wire logic                     reset_protect_i,
    input  wire logic                     descriptor_emulation_select_i,
    // Descriptor length lookup
    input  wire logic                     desc_req_i,
    input  wire gpvdl_desc_kind_t         desc_kind_i,
    output logic                          desc_valid_o,
    output logic      [`GPVDL_LEN_W-1:0]  desc_len_o,
    output logic                          desc_present_o,
    output logic      [`GPVDL_LEN_W-1:0]  ss_poll_interval_o
);

    // ------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------
    gpvdl_state_t                 st_reg;
    gpvdl_state_t                 st_next;
    logic [`GPVDL_PIN_W-1:0]      pin_sampled;
    logic                         setup_phase;
    logic                         access_done;
    logic                         wr_done;
    logic                         hit;
    logic [31:0]                  rd_data;
    logic                         bus_reset;
    logic                         image_load;
    logic                         emul_active;
    logic [31:0]                  pin_merged;
    logic [31:0]                  cap_merged;
    logic [31:0]                  ss_merged;

    // Merges write data into a register word under the byte strobes.
    function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    assign setup_phase = apb_i.psel & ~apb_i.penable;
    assign access_done = apb_i.psel & apb_i.penable & st_reg.rsp.pready;
    assign wr_done     = access_done & apb_i.pwrite;
    assign bus_reset   = (usb_reset_i | lite_soft_reset_i) & ~reset_protect_i;
    assign image_load  = cfg_load_i & cfg_present_i;
    assign emul_active = ~cfg_present_i & descriptor_emulation_select_i;

    // ------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------
    gpvdl_pin_sync #(
        .W        (`GPVDL_PIN_W)
    ) u_pin_sync (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .async_i  (pin_level_i),
        .level_o  (pin_sampled)
    );

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        hit     = 1'b1;
        unique case (apb_i.paddr)
            `GPVDL_OFS_PIN_VALUE: begin
                rd_data[`GPVDL_PIN_W-1:0] = pin_sampled;
            end
            `GPVDL_OFS_CAP_LEN: begin
                rd_data[`GPVDL_CAP_LEN_MSB:`GPVDL_CAP_LEN_LSB] = st_reg.cap_len;
            end
            `GPVDL_OFS_SS_LEN: begin
                rd_data[`GPVDL_SS_POLL_MSB:`GPVDL_SS_POLL_LSB] = st_reg.ss.poll;
                rd_data[`GPVDL_SS_DEV_MSB:`GPVDL_SS_DEV_LSB]   = st_reg.ss.dev_len;
                rd_data[`GPVDL_SS_CFG_MSB:`GPVDL_SS_CFG_LSB]   = st_reg.ss.cfg_len;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Write values merged over the old fields; reserved bits follow pwdata and are not stored.
    assign pin_merged = merge_strb({1'b0, st_reg.pin_value}, apb_i.pwdata, apb_i.pstrb);
    assign cap_merged = merge_strb({24'h00_0000, st_reg.cap_len}, apb_i.pwdata, apb_i.pstrb);
    assign ss_merged  = merge_strb({8'h00, st_reg.ss}, apb_i.pwdata, apb_i.pstrb);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next            = st_reg;
        st_next.rsp.pready = setup_phase;
        if (setup_phase) begin
            st_next.rsp.prdata  = apb_i.pwrite ? 32'h0000_0000 : rd_data;
            st_next.rsp.pslverr = ~hit;
        end
        // Bus resets act first, so a load or a write in the same cycle wins.
        if (bus_reset) begin
            if (cfg_present_i && st_reg.image_valid) begin
                st_next.pin_value    = st_reg.pin_image;
                st_next.pins_enabled = 1'b1;
            end else begin
                st_next.pins_enabled = 1'b0;
            end
            st_next.cap_len    = `GPVDL_CAP_LEN_RST;
            st_next.ss.poll    = `GPVDL_SS_POLL_RST;
            st_next.ss.dev_len = `GPVDL_SS_DEV_RST;
            st_next.ss.cfg_len = `GPVDL_SS_CFG_RST;
        end
        if (image_load) begin
            st_next.pin_image    = cfg_pin_image_i;
            st_next.pin_value    = cfg_pin_image_i;
            st_next.image_valid  = 1'b1;
            st_next.pins_enabled = 1'b1;
        end
        // Attribute writes are stored even with memory present; software keeps off them.
        if (wr_done && hit) begin
            unique case (apb_i.paddr)
                `GPVDL_OFS_PIN_VALUE: begin
                    st_next.pin_value    = pin_merged[`GPVDL_PIN_W-1:0];
                    st_next.pins_enabled = 1'b1;
                end
                `GPVDL_OFS_CAP_LEN: begin
                    st_next.cap_len = cap_merged[`GPVDL_CAP_LEN_MSB:`GPVDL_CAP_LEN_LSB];
                end
                `GPVDL_OFS_SS_LEN: begin
                    st_next.ss.poll    = ss_merged[`GPVDL_SS_POLL_MSB:`GPVDL_SS_POLL_LSB];
                    st_next.ss.dev_len = ss_merged[`GPVDL_SS_DEV_MSB:`GPVDL_SS_DEV_LSB];
                    st_next.ss.cfg_len = ss_merged[`GPVDL_SS_CFG_MSB:`GPVDL_SS_CFG_LSB];
                end
                default: begin
                    st_next.rsp.pslverr = 1'b1;
                end
            endcase
        end
        // Enables follow the new enable state so pins release with it.
        st_next.oe_n = ~(pin_dir_i & {`GPVDL_PIN_W{st_next.pins_enabled}});
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg           <= '0;
            st_reg.pin_value <= `GPVDL_PIN_VALUE_RST;
            st_reg.oe_n      <= '1;
            st_reg.cap_len   <= `GPVDL_CAP_LEN_RST;
            st_reg.ss.poll   <= `GPVDL_SS_POLL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign apb_o              = st_reg.rsp;
    assign pin_out_o          = st_reg.pin_value;
    assign pin_oe_n_o         = st_reg.oe_n;
    assign ss_poll_interval_o = st_reg.ss.poll;

    // ------------------------------------------------------------------
    // Descriptor length lookup
    // ------------------------------------------------------------------
    gpvdl_desc_len u_desc_len (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .req_i      (desc_req_i),
        .kind_i     (desc_kind_i),
        .emul_i     (emul_active),
        .cap_len_i  (st_reg.cap_len),
        .ss_i       (st_reg.ss),
        .valid_o    (desc_valid_o),
        .len_o      (desc_len_o),
        .present_o  (desc_present_o)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_write_drives_pin: assert property (
        (wr_done && apb_i.paddr == `GPVDL_OFS_PIN_VALUE && apb_i.pstrb == 4'hf)
        |=> (pin_out_o == $past(apb_i.pwdata[30:0])
             && pin_oe_n_o == ~$past(pin_dir_i)))
        else $error("written pin value not driven");

    a_read_pin_level: assert property (
        (setup_phase && !apb_i.pwrite && apb_i.paddr == `GPVDL_OFS_PIN_VALUE)
        |=> (apb_o.pready && apb_o.prdata == {1'b0, $past(pin_sampled)}))
        else $error("pin read does not return sampled level");

    a_image_loads: assert property (
        (image_load && !wr_done)
        |=> (pin_out_o == $past(cfg_pin_image_i) && pin_oe_n_o == ~$past(pin_dir_i)))
        else $error("configuration image not loaded");

    a_no_mem_undriven: assert property (
        (!cfg_present_i && !st_reg.pins_enabled && !wr_done) |=> (&pin_oe_n_o))
        else $error("pins driven without configuration memory");

    a_reset_disables: assert property (
        (bus_reset && !cfg_present_i && !image_load && !wr_done) |=> (&pin_oe_n_o))
        else $error("bus reset did not release pins");

    a_reset_restores: assert property (
        (bus_reset && cfg_present_i && st_reg.image_valid && !image_load && !wr_done)
        |=> (pin_out_o == $past(st_reg.pin_image)))
        else $error("bus reset did not restore image value");

    a_protect_holds: assert property (
        ((usb_reset_i || lite_soft_reset_i) && reset_protect_i && !wr_done && !image_load)
        |=> ($stable(pin_out_o) && $stable(st_reg.cap_len) && $stable(st_reg.ss)))
        else $error("protected registers disturbed by bus reset");

    a_cap_len_reset: assert property (
        (bus_reset && !wr_done) |=> (st_reg.cap_len == 8'h00))
        else $error("capability length not cleared");

    a_poll_reset: assert property (
        (bus_reset && !wr_done) |=> (ss_poll_interval_o == 8'h06 && st_reg.ss.dev_len == 8'h00))
        else $error("polling interval not restored");

    a_poll_write: assert property (
        (wr_done && apb_i.paddr == `GPVDL_OFS_SS_LEN && apb_i.pstrb == 4'hf)
        |=> (ss_poll_interval_o == $past(apb_i.pwdata[23:16])))
        else $error("polling interval write lost");

    a_unmapped_err: assert property (
        (setup_phase && !hit) |=> (apb_o.pready && apb_o.pslverr) ##1 !apb_o.pready)
        else $error("unmapped access not answered with error");

endmodule

// ==== test/gpvdl_top_tb_top.sv ====
// Self-checking testbench for the pin value and descriptor length register bank.
// Assumes gpvdl_params.svh is on the include path and the design files are compiled first.
`timescale 1ns/1ps
`include "gpvdl_params.svh"

module gpvdl_top_tb_top
    import gpvdl_pkg::*;
;
    logic                     clk_i;
    logic                     rst_n_i;
    gpvdl_apb_req_t           apb;
    gpvdl_apb_rsp_t           apb_rsp;
    logic [`GPVDL_PIN_W-1:0]  pin_level;
    logic [`GPVDL_PIN_W-1:0]  pin_dir;
    logic [`GPVDL_PIN_W-1:0]  pin_out;
    logic [`GPVDL_PIN_W-1:0]  pin_oe_n;
    logic [`GPVDL_PIN_W-1:0]  cfg_image;
    logic                     cfg_present;
    logic                     cfg_load;
    logic                     usb_reset;
    logic                     lite_reset;
    logic                     protect;
    logic                     emul_sel;
    logic                     desc_req;
    gpvdl_desc_kind_t         desc_kind;
    logic                     desc_valid;
    logic                     desc_present;
    logic [`GPVDL_LEN_W-1:0]  desc_len;
    logic [`GPVDL_LEN_W-1:0]  ss_poll;
    int                       n_errors;
    int                       num_checks;

    gpvdl_top u_gpvdl_top (
        .clk_i                         (clk_i),
        .rst_n_i                       (rst_n_i),
        .apb_i                         (apb),
        .apb_o                         (apb_rsp),
        .pin_level_i                   (pin_level),
        .pin_dir_i                     (pin_dir),
        .pin_out_o                     (pin_out),
        .pin_oe_n_o                    (pin_oe_n),
        .cfg_present_i                 (cfg_present),
        .cfg_load_i                    (cfg_load),
        .cfg_pin_image_i               (cfg_image),
        .usb_reset_i                   (usb_reset),
        .lite_soft_reset_i             (lite_reset),
        .reset_protect_i               (protect),
        .descriptor_emulation_select_i (emul_sel),
        .desc_req_i                    (desc_req),
        .desc_kind_i                   (desc_kind),
        .desc_valid_o                  (desc_valid),
        .desc_len_o                    (desc_len),
        .desc_present_o                (desc_present),
        .ss_poll_interval_o            (ss_poll)
    );

    always #10 clk_i = ~clk_i;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("Checks: %0d, errors: %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // APB transfer: setup, then access held until pready is sampled high.
    task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_i);
        apb.psel <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite <= wr;
        apb.paddr <= addr;
        apb.pwdata <= wd;
        apb.pstrb <= wr ? 4'hf : 4'h0;
        @(posedge clk_i);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready_wait", 32'h1, 32'h0);
            test_done();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        @(negedge clk_i);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic        er;
        apb_xfer(1'b0, addr, 32'h0000_0000, rd, er);
        chk(name, exp, rd);
        chk("pslverr", 32'h0, {31'h0, er});
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic        er;
        apb_xfer(1'b1, addr, wd, rd, er);
    endtask

    task automatic bus_reset(input logic lite);
        @(posedge clk_i);
        usb_reset <= ~lite;
        lite_reset <= lite;
        @(posedge clk_i);
        usb_reset <= 1'b0;
        lite_reset <= 1'b0;
        @(negedge clk_i);
    endtask

    task automatic desc_chk(input gpvdl_desc_kind_t k, input logic [7:0] exp);
        @(posedge clk_i);
        desc_req <= 1'b1;
        desc_kind <= k;
        @(posedge clk_i);
        desc_req <= 1'b0;
        @(negedge clk_i);
        chk("desc_valid", 32'h1, {31'h0, desc_valid});
        chk("desc_len", {24'h0, exp}, {24'h0, desc_len});
        chk("desc_present", {31'h0, exp != 8'h00}, {31'h0, desc_present});
        @(negedge clk_i);
        chk("desc_valid_drop", 32'h0, {31'h0, desc_valid});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values();
        chk("oe_n_reset", 32'h7FFF_FFFF, {1'b0, pin_oe_n});
        chk("poll_out", 32'h0000_0006, {24'h0, ss_poll});
        rd_chk("cap_len", `GPVDL_OFS_CAP_LEN, 32'h0000_0000);
        rd_chk("ss_len", `GPVDL_OFS_SS_LEN, 32'h0006_0000);
    endtask

    task automatic t_pins();
        logic [31:0] rd;
        logic        er;
        @(posedge clk_i);
        pin_dir <= 31'h0F0F_00FF;
        wr(`GPVDL_OFS_PIN_VALUE, 32'hFFFF_AA55);
        chk("pin_out", 32'h7FFF_AA55, {1'b0, pin_out});
        chk("pin_oe_n", 32'h70F0_FF00, {1'b0, pin_oe_n});
        @(posedge clk_i);
        pin_level <= 31'h2A5A_C3E1;
        repeat (5) @(posedge clk_i);
        rd_chk("pin_read", `GPVDL_OFS_PIN_VALUE, 32'h2A5A_C3E1);
        apb_xfer(1'b0, 12'h108, 32'h0000_0000, rd, er);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
    endtask

    task automatic t_image();
        @(posedge clk_i);
        cfg_present <= 1'b1;
        cfg_image <= 31'h1234_5678;
        @(posedge clk_i);
        cfg_load <= 1'b1;
        @(posedge clk_i);
        cfg_load <= 1'b0;
        @(negedge clk_i);
        chk("image_load", 32'h1234_5678, {1'b0, pin_out});
        chk("image_oe_n", 32'h70F0_FF00, {1'b0, pin_oe_n});
        wr(`GPVDL_OFS_PIN_VALUE, 32'h0000_0001);
        bus_reset(1'b0);
        chk("usb_restore", 32'h1234_5678, {1'b0, pin_out});
        wr(`GPVDL_OFS_PIN_VALUE, 32'h0000_0003);
        @(posedge clk_i);
        protect <= 1'b1;
        bus_reset(1'b1);
        chk("protected_pins", 32'h0000_0003, {1'b0, pin_out});
        @(posedge clk_i);
        protect <= 1'b0;
        bus_reset(1'b1);
        chk("lite_restore", 32'h1234_5678, {1'b0, pin_out});
        @(posedge clk_i);
        cfg_present <= 1'b0;
        bus_reset(1'b0);
        chk("no_mem_release", 32'h7FFF_FFFF, {1'b0, pin_oe_n});
    endtask

    task automatic t_attrs();
        wr(`GPVDL_OFS_CAP_LEN, 32'hFFFF_FF5A);
        wr(`GPVDL_OFS_SS_LEN, 32'hFF0A_121E);
        rd_chk("cap_len_rw", `GPVDL_OFS_CAP_LEN, 32'h0000_005A);
        rd_chk("ss_len_rw", `GPVDL_OFS_SS_LEN, 32'h000A_121E);
        chk("poll_out_rw", 32'h0000_000A, {24'h0, ss_poll});
        @(posedge clk_i);
        emul_sel <= 1'b1;
        desc_chk(GPVDL_DESC_CAP, 8'h5A);
        desc_chk(GPVDL_DESC_SS_DEV, 8'h12);
        desc_chk(GPVDL_DESC_SS_CFG, 8'h1E);
        desc_chk(gpvdl_desc_kind_t'(2'b11), 8'h00);
        @(posedge clk_i);
        emul_sel <= 1'b0;
        desc_chk(GPVDL_DESC_SS_DEV, 8'h00);
        @(posedge clk_i);
        protect <= 1'b1;
        bus_reset(1'b1);
        rd_chk("ss_protected", `GPVDL_OFS_SS_LEN, 32'h000A_121E);
        @(posedge clk_i);
        protect <= 1'b0;
        bus_reset(1'b0);
        rd_chk("cap_cleared", `GPVDL_OFS_CAP_LEN, 32'h0000_0000);
        rd_chk("ss_cleared", `GPVDL_OFS_SS_LEN, 32'h0006_0000);
        @(posedge clk_i);
        emul_sel <= 1'b1;
        desc_chk(GPVDL_DESC_SS_CFG, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        apb = '0;
        pin_level = 31'h0000_0000;
        pin_dir = 31'h0000_0000;
        cfg_image = 31'h0000_0000;
        {cfg_present, cfg_load, usb_reset, lite_reset, protect, emul_sel, desc_req} = 7'h00;
        desc_kind = GPVDL_DESC_CAP;
        n_errors = 0;
        num_checks = 0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        t_reset_values();
        t_pins();
        t_image();
        t_attrs();
        test_done();
    end

    initial begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule
